// file: shaft_encoder_word_sequencer.v
// Shaft encoder word sequencer: state counter, steering, power control
// Contract
// - State 10 grounds the fine encoder common return.
// - Fine encoder enabled: accept all 19 advanced and 19 retarded lines.
// - State 10 presents fine bits 10 to 18 as third word.
// - Third clear/clock trailing edge advances counter from 10 to 11.
// - State 11 presents fine bits 0 to 9 as fourth word.
// - Sequence repeats until 90th frame pulse removes encoder supply.
// - Read pulse presets first power flip-flop, arms the second.
// - Frame mark resets counter, grounds coarse return, steers coarse bits 10-18.
// - First clear/clock trailing edge: state 01, coarse bits 0-9.
// - Each bit above bit 0 reads advanced brush if lower bit high, else retarded.
// - After read, first 90th pulse powers on, next powers off and idles.
`timescale 1ns/1ps
`default_nettype none
`include "shaft_encoder_consts.vh"
module shaft_encoder_word_sequencer (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst_b,
  // Telemetry timing pins
  input  wire                  frame_mark,
  input  wire                  clear_clock,
  input  wire                  frame90_pulse,
  input  wire                  read_cmd,
  // Coarse encoder brushes
  input  wire [`ENC_BITS-1:0]  coarse_adv,
  input  wire [`ENC_BITS-1:0]  coarse_ret,
  // Fine encoder brushes
  input  wire [`ENC_BITS-1:0]  fine_adv,
  input  wire [`ENC_BITS-1:0]  fine_ret,
  // Encoder commons, low grounds the return
  output reg                   coarse_common_b,
  output reg                   fine_common_b,
  // Output word and supply
  output reg  [`WORD_BITS-1:0] data_word,
  output reg  [1:0]            word_state,
  output reg                   encoder_power
);
  // Two-stage synchronisers on all pins
  reg [3:0]             ctl_s1_q;
  reg [3:0]             ctl_s2_q;
  reg [3:0]             ctl_s3_q;
  reg [4*`ENC_BITS-1:0] brush_s1_q;
  reg [4*`ENC_BITS-1:0] brush_s2_q;

  // Timing pins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_s1_q <= 4'h0;
      ctl_s2_q <= 4'h0;
    end else begin
      ctl_s1_q <= {read_cmd, frame90_pulse, clear_clock, frame_mark};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // Edge register, reset to the idle low level so no edge follows reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ctl_s3_q <= 4'h0;
    else
      ctl_s3_q <= ctl_s2_q;
  end

  // Brushes are static while read, so the wide word may cross here
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brush_s1_q <= {4*`ENC_BITS{1'h0}};
      brush_s2_q <= {4*`ENC_BITS{1'h0}};
    end else begin
      brush_s1_q <= {fine_ret, fine_adv, coarse_ret, coarse_adv};
      brush_s2_q <= brush_s1_q;
    end
  end

  // Edge flags; clear/clock acts on its fall, the other pins on their rise
  localparam [3:0] EDGE_FALL = 4'h2;
  wire [3:0] pin_edge;
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_pin_edge
      assign pin_edge[p] = EDGE_FALL[p] ? (~ctl_s2_q[p] & ctl_s3_q[p])
                                        : (ctl_s2_q[p] & ~ctl_s3_q[p]);
    end
  endgenerate
  wire mark_rise = pin_edge[0];
  wire clk_fall  = pin_edge[1];
  wire f90_rise  = pin_edge[2];
  wire read_rise = pin_edge[3];

  wire [`ENC_BITS-1:0] coarse_code;
  wire [`ENC_BITS-1:0] fine_code;
  brush_resolver u_coarse (
    .adv  (brush_s2_q[`ENC_BITS-1:0]),
    .ret  (brush_s2_q[2*`ENC_BITS-1:`ENC_BITS]),
    .code (coarse_code)
  );
  brush_resolver u_fine (
    .adv  (brush_s2_q[3*`ENC_BITS-1:2*`ENC_BITS]),
    .ret  (brush_s2_q[4*`ENC_BITS-1:3*`ENC_BITS]),
    .code (fine_code)
  );

  // Word state counter; a frame mark wins over a clear/clock fall
  reg [1:0] word_state_counter_q;
  reg [1:0] word_state_counter_d;
  always @* begin
    word_state_counter_d = word_state_counter_q;
    if (mark_rise)
      word_state_counter_d = `ST_COARSE_HI;
    else if (clk_fall)
      word_state_counter_d = word_state_counter_q + 2'h1;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      word_state_counter_q <= `ST_COARSE_HI;
    else
      word_state_counter_q <= word_state_counter_d;
  end

  // Encoder power flip-flops as one-hot states: idle, armed by a read
  // command, and supply on
  localparam [2:0] PWR_IDLE  = `PWR_IDLE;
  localparam [2:0] PWR_ARMED = `PWR_ARMED;
  localparam [2:0] PWR_ON    = `PWR_ON;
  reg [2:0] encoder_power_flipflops_q;
  reg [2:0] encoder_power_flipflops_d;
  always @* begin
    encoder_power_flipflops_d = encoder_power_flipflops_q;
    case (encoder_power_flipflops_q)
      PWR_IDLE: begin
        // A read while armed or on is ignored
        if (read_rise)
          encoder_power_flipflops_d = PWR_ARMED;
      end
      PWR_ARMED: begin
        if (f90_rise)
          encoder_power_flipflops_d = PWR_ON;
      end
      PWR_ON: begin
        if (f90_rise)
          encoder_power_flipflops_d = PWR_IDLE;
      end
      default:
        encoder_power_flipflops_d = PWR_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      encoder_power_flipflops_q <= `PWR_IDLE;
    else
      encoder_power_flipflops_q <= encoder_power_flipflops_d;
  end

  // Supply and commons follow the next state, so they switch in the
  // same edge as the counter
  wire pwr_on_d = (encoder_power_flipflops_d == PWR_ON);
  wire coarse_common_gate_d = pwr_on_d & ~word_state_counter_d[1];
  wire fine_common_power_gate_d = pwr_on_d & word_state_counter_d[1];

  // Steering from the next state; brush data reaches it two edges after
  // its common is grounded, well inside one clear/clock period
  reg [`WORD_BITS-1:0] word_d;
  always @* begin
    case (word_state_counter_d)
      `ST_COARSE_HI:
        word_d = {1'h0, coarse_code[`ENC_BITS-1:`HI_FIELD_LSB]};
      `ST_COARSE_LO:
        word_d = coarse_code[`WORD_BITS-1:0];
      `ST_FINE_HI:
        word_d = {1'h0, fine_code[`ENC_BITS-1:`HI_FIELD_LSB]};
      default:
        word_d = fine_code[`WORD_BITS-1:0];
    endcase
  end

  // Counter state as held
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      word_state <= `ST_COARSE_HI;
    else
      word_state <= word_state_counter_d;
  end

  // Supply switch
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      encoder_power <= 1'h0;
    else
      encoder_power <= pwr_on_d;
  end

  // Unpowered encoders give no data, so the word is held at zero then
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      data_word <= {`WORD_BITS{1'h0}};
    else if (pwr_on_d)
      data_word <= word_d;
    else
      data_word <= {`WORD_BITS{1'h0}};
  end

  // Coarse return, active low; released while the supply is off
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      coarse_common_b <= 1'h1;
    else
      coarse_common_b <= ~coarse_common_gate_d;
  end

  // Fine return, active low; never grounded together with the coarse one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      fine_common_b <= 1'h1;
    else
      fine_common_b <= ~fine_common_power_gate_d;
  end
endmodule // shaft_encoder_word_sequencer
`default_nettype wire

// file: shaft_encoder_consts.vh
// Constants for the shaft encoder word sequencer
`ifndef SHAFT_ENCODER_CONSTS_VH
`define SHAFT_ENCODER_CONSTS_VH
`define ENC_BITS        19
`define WORD_BITS       10
`define ST_COARSE_HI    2'h0
`define ST_COARSE_LO    2'h1
`define ST_FINE_HI      2'h2
`define ST_FINE_LO      2'h3
`define HI_FIELD_LSB    10
`define PWR_IDLE        3'h1
`define PWR_ARMED       3'h2
`define PWR_ON          3'h4
`endif

// file: brush_resolver.v
// Dual-brush track selection for one encoder
`timescale 1ns/1ps
`default_nettype none
`include "shaft_encoder_consts.vh"
module brush_resolver (
  // Brush lines
  input  wire [`ENC_BITS-1:0] adv,
  input  wire [`ENC_BITS-1:0] ret,
  // Resolved code
  output wire [`ENC_BITS-1:0] code
);
  // Bit 0 has no lower bit, so it is read from the advanced brush
  assign code[0] = adv[0];
  genvar i;
  generate
    for (i = 1; i < `ENC_BITS; i = i + 1) begin : g_bit
      assign code[i] = code[i-1] ? adv[i] : ret[i];
    end
  endgenerate
endmodule // brush_resolver
`default_nettype wire

// file: encoder_model.sv
// Dual-brush shaft encoder model
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input  wire logic        common_b,
  input  wire logic [18:0] pos,
  output logic      [18:0] adv,
  output logic      [18:0] ret
);
  // Unread brush is wrong above bit 0, so a swapped track shows up in the word
  assign adv = common_b ? ~pos : pos ^ ~{pos[17:0], 1'h1};
  assign ret = common_b ? ~pos : pos ^ {pos[17:0], 1'h0};
endmodule // encoder_model
`default_nettype wire

// file: shaft_encoder_word_sequencer_props.sv
// Checker for the shaft encoder word sequencer
`timescale 1ns/1ps
`default_nettype none
module shaft_encoder_word_sequencer_props (
  // Clock, reset and timing pins
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       frame_mark,
  input wire logic       clear_clock,
  input wire logic       frame90_pulse,
  // Design outputs
  input wire logic       coarse_common_b,
  input wire logic       fine_common_b,
  input wire logic       encoder_power,
  input wire logic [9:0] data_word,
  input wire logic [1:0] word_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence step_s; $fell(clear_clock) && !frame_mark; endsequence
  sequence calm_s; encoder_power && $stable(word_state); endsequence
  a_state_steps: assert property (step_s |-> ##[2:4] $changed(word_state))
    else $error("state did not step");
  a_frame_clears: assert property ($rose(frame_mark) |-> ##[2:4]
    word_state == 2'h0) else $error("frame mark missed");
  a_fine_common: assert property (calm_s ##0 word_state[1] |->
    !fine_common_b && coarse_common_b) else $error("fine common");
  a_coarse_common: assert property (calm_s ##0 !word_state[1] |->
    !coarse_common_b && fine_common_b) else $error("coarse common");
  a_hi_word_msb: assert property (calm_s ##0 !word_state[0] |->
    !data_word[9]) else $error("high word msb set");
  a_single_common: assert property (coarse_common_b || fine_common_b)
    else $error("both commons grounded");
  a_power_on: assert property ($rose(encoder_power) |->
    $past(frame90_pulse, 3)) else $error("power on uncaused");
  a_power_off: assert property ($fell(encoder_power) |->
    $past(frame90_pulse, 3)) else $error("power off uncaused");
  a_idle_word: assert property (!encoder_power && $stable(encoder_power)
    |-> data_word == 10'h0) else $error("word while off");
endmodule // shaft_encoder_word_sequencer_props
bind shaft_encoder_word_sequencer shaft_encoder_word_sequencer_props i_props
  (.clk, .rst_b, .frame_mark, .clear_clock, .frame90_pulse, .coarse_common_b,
   .fine_common_b, .encoder_power, .data_word, .word_state);
`default_nettype wire

// file: shaft_encoder_word_sequencer_test.sv
// Testbench for the shaft encoder word sequencer
`timescale 1ns/1ps
`default_nettype none
module shaft_encoder_word_sequencer_test;
  logic        clk = 0, rst_b = 0, fm = 0, cc = 0, f90 = 0, rd = 0;
  logic [18:0] cp = 19'h5_a3c6, fp = 19'h2_9e71;
  wire  [18:0] ca, cr, fa, fr;
  wire         cb, fb, pw;
  wire  [9:0]  dw;
  wire  [1:0]  ws;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  shaft_encoder_word_sequencer i_dut (.clk(clk), .rst_b(rst_b),
    .frame_mark(fm), .clear_clock(cc), .frame90_pulse(f90), .read_cmd(rd),
    .coarse_adv(ca), .coarse_ret(cr), .fine_adv(fa), .fine_ret(fr),
    .coarse_common_b(cb), .fine_common_b(fb), .data_word(dw),
    .word_state(ws), .encoder_power(pw));
  encoder_model i_coarse (.common_b(cb), .pos(cp), .adv(ca), .ret(cr));
  encoder_model i_fine (.common_b(fb), .pos(fp), .adv(fa), .ret(fr));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize;
    $display("mismatches %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  localparam int P_MARK = 0, P_CLEAR = 1, P_F90 = 2, P_READ = 3;
  task set_pin(input int pin, input logic v);
    case (pin)
      P_MARK:  fm = v;
      P_CLEAR: cc = v;
      P_F90:   f90 = v;
      default: rd = v;
    endcase
  endtask
  // Three cycles high, then settle past the sync delay after the fall
  task pulse(input int pin);
    @(negedge clk) set_pin(pin, 1'h1);
    repeat (3) @(negedge clk);
    set_pin(pin, 1'h0);
    repeat (6) @(negedge clk);
  endtask
  task t_power;
    chk("reset_power", 10'h0, pw);
    chk("reset_commons", 10'h3, {fb, cb});
    pulse(P_READ);
    chk("power", 10'h0, pw);
    pulse(P_F90);
    chk("power", 10'h1, pw);
    chk("commons_on", 10'h2, {fb, cb});
    $display("test power done");
  endtask
  task t_words;
    pulse(P_MARK);
    chk("word0", {1'h0, cp[18:10]}, dw);
    chk("commons0", 10'h2, {fb, cb});
    pulse(P_CLEAR);
    chk("state1", 10'h1, ws);
    chk("word1", cp[9:0], dw);
    pulse(P_CLEAR);
    chk("state2", 10'h2, ws);
    chk("word2", {1'h0, fp[18:10]}, dw);
    chk("commons2", 10'h1, {fb, cb});
    pulse(P_CLEAR);
    chk("state3", 10'h3, ws);
    chk("word3", fp[9:0], dw);
    pulse(P_CLEAR);
    chk("word4", {1'h0, cp[18:10]}, dw);
    pulse(P_CLEAR);
    pulse(P_CLEAR);
    pulse(P_MARK);
    chk("mark_state", 10'h0, ws);
    chk("mark_commons", 10'h2, {fb, cb});
    chk("mark_word", {1'h0, cp[18:10]}, dw);
    $display("test words done");
  endtask
  task t_off;
    pulse(P_F90);
    chk("power_off", 10'h0, pw);
    chk("idle_word", 10'h0, dw);
    chk("idle_commons", 10'h3, {fb, cb});
    pulse(P_F90);
    chk("idle_f90", 10'h0, pw);
    pulse(P_READ);
    pulse(P_F90);
    chk("rearm", 10'h1, pw);
    $display("test off done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1;
    @(negedge clk);
    t_power;
    t_words;
    t_off;
    summarize;
  end
endmodule // shaft_encoder_word_sequencer_test
`default_nettype wire
